// ### hdl/sar_adc_sequencer.sv
// Overview of operation
// - a conversion starts only on the selected trigger
// - approximation register is cleared at every conversion start
// - trial bit set to one, kept if reference below input, else cleared
// - bits tried from 7 down to 0, then code stored as channel result
// - ladder threshold follows current code: zero, else ref/256*(n-0.5)
// - mode field 00 one-shot, 01 repeat, others sweep modes, which start no conversion
// - trigger select bit picks software start or external pin
// - one-shot converts the selected channel and requests an interrupt
// - software one-shot: result and request after 57 conversion ticks
// - software one-shot clears start flag after completion, then halts
// - external falling edge starts conversion only while start flag set
// - external one-shot keeps start flag, edges retrigger even mid-run
// - repeat mode never requests interrupt nor clears start flag
// - repeat mode stores each result and restarts immediately
// - unselected channel pins remain ordinary port pins
// - conversion clock is input clock divided by 8, or by 4 when fast
// - three-bit channel field selects input 0 to 7 in binary
// - request bit clears on acceptance; software may set or clear it
// - result of channel in conversion reads previous completed value
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer
  import sar_adc_seq_pkg::*;
(
  input  wire logic                                   clk_i,
  input  wire logic                                   rst_i,
  input  wire logic                                   ce_i,
  input  wire logic                                   cyc_i,
  input  wire logic                                   stb_i,
  input  wire logic                                   we_i,
  input  wire logic [sar_adc_seq_pkg::ADR_WIDTH-1:0]  adr_i,
  input  wire logic [3:0]                             sel_i,
  input  wire logic [31:0]                            dat_i,
  output logic      [31:0]                            dat_o,
  output logic                                        ack_o,
  input  wire logic                                   comp_i,
  input  wire logic                                   ext_conv_trigger_n_i,
  input  wire logic                                   irq_ack_i,
  output logic      [7:0]                             dac_code_o,
  output logic      [2:0]                             ch_sel_o,
  output logic      [7:0]                             analog_in_en_o,
  output logic                                        busy_o,
  output logic                                        irq_o
);
  import sar_adc_seq_pkg::*;

  typedef enum logic {IDLE, CONV} conv_state_type;

  // ***********************************************************
  // state
  // ***********************************************************
  conv_state_type state, next_state;
  logic [7:0]     ctrl, next_ctrl;
  logic [2:0]     prio, next_prio;
  logic           irq_req, next_irq_req;
  logic [7:0]     sar, next_sar;
  logic [7:0]     final_code;
  logic [2:0]     bit_idx, next_bit_idx;
  logic [2:0]     phase, next_phase;
  logic [5:0]     tick_cnt, next_tick_cnt;
  logic [2:0]     div, next_div;
  logic [7:0]     result [8];
  logic [31:0]    next_dat;
  logic           next_ack;
  logic           trig_s1, trig_s2, trig_s3;

  logic [7:0]     index;
  logic           wr, rd, wr_ctrl, wr_irq;
  logic           ext_fall, trigger, tick, done;
  logic [1:0]     mode;
  logic [2:0]     ch;
  logic           ext_sel, start;

  assign index   = adr_i[ADR_WIDTH-1:2];
  assign wr      = cyc_i & stb_i & we_i & ~ack_o & sel_i[0];
  assign rd      = cyc_i & stb_i & ~we_i & ~ack_o;
  assign wr_ctrl = wr & (index == CTRL_INDEX);
  assign wr_irq  = wr & (index == IRQ_INDEX);
  assign mode    = ctrl[MODE_LSB +: 2];
  assign ch      = ctrl[CH_LSB +: 3];
  assign ext_sel = ctrl[TRIG_SEL_BIT];
  assign start   = ctrl[START_BIT];

  // ***********************************************************
  // external trigger synchroniser
  // ***********************************************************
  // two-stage sync, edge from later stages
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trig_s1 <= 1'b1;
      trig_s2 <= 1'b1;
      trig_s3 <= 1'b1;
    end else if (ce_i) begin
      trig_s1 <= ext_conv_trigger_n_i;
      trig_s2 <= trig_s1;
      trig_s3 <= trig_s2;
    end
  end
  assign ext_fall = trig_s3 & ~trig_s2;

  // trigger source and gating by start flag
  assign trigger = (mode == MODE_ONE_SHOT || mode == MODE_REPEAT) &&
                   start && (ext_sel ? ext_fall : (state == IDLE));

  // ***********************************************************
  // conversion clock divider
  // ***********************************************************
  // divide by 8, or by 4 when fast flag set
  always_comb begin
    next_div = div + 3'h1;
    tick     = 1'b0;
    if (div == (ctrl[FREQ_BIT] ? DIV_FAST_LAST : DIV_SLOW_LAST)) begin
      next_div = 3'h0;
      tick     = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div <= 3'h0;
    end else if (ce_i) begin
      div <= next_div;
    end
  end

  // ***********************************************************
  // sequencer
  // ***********************************************************
  assign final_code = {sar[7:1], comp_i};

  always_comb begin
    next_state    = state;
    next_sar      = sar;
    next_bit_idx  = bit_idx;
    next_phase    = phase;
    next_tick_cnt = tick_cnt;
    done          = 1'b0;
    if (trigger) begin
      next_state    = CONV;
      next_sar      = SAR_CLEAR;
      next_tick_cnt = 6'h00;
      next_phase    = 3'h0;
      next_bit_idx  = 3'h7;
    end else if (state == CONV && (!start ||
                 !(mode == MODE_ONE_SHOT || mode == MODE_REPEAT))) begin
      next_state = IDLE;
    end else if (state == CONV && tick) begin
      next_tick_cnt = tick_cnt + 6'h01;
      if (tick_cnt == 6'h00) begin
        next_sar[7] = 1'b1;
      end else if (phase == BIT_TICKS - 3'h1) begin
        next_sar[bit_idx] = comp_i;
        next_phase        = 3'h0;
        if (bit_idx == 3'h0) begin
          done = 1'b1;
        end else begin
          next_bit_idx           = bit_idx - 3'h1;
          next_sar[bit_idx-3'h1] = 1'b1;
        end
      end else begin
        next_phase = phase + 3'h1;
      end
      if (done) begin
        next_tick_cnt = 6'h00;
        next_bit_idx  = 3'h7;
        if (mode == MODE_REPEAT) begin
          next_sar = SAR_CLEAR;
        end else begin
          next_state = IDLE;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= IDLE;
      sar      <= SAR_CLEAR;
      bit_idx  <= 3'h7;
      phase    <= 3'h0;
      tick_cnt <= 6'h00;
    end else if (ce_i) begin
      state    <= next_state;
      sar      <= next_sar;
      bit_idx  <= next_bit_idx;
      phase    <= next_phase;
      tick_cnt <= next_tick_cnt;
    end
  end

  // ***********************************************************
  // control and interrupt registers
  // ***********************************************************
  always_comb begin
    next_ctrl    = ctrl;
    next_prio    = prio;
    next_irq_req = irq_req;
    if (done && mode == MODE_ONE_SHOT && !ext_sel) begin
      next_ctrl[START_BIT] = 1'b0;
    end
    if (wr_ctrl) begin
      next_ctrl = dat_i[7:0];
    end
    if (irq_ack_i) begin
      next_irq_req = 1'b0;
    end
    if (wr_irq) begin
      next_prio    = dat_i[PRIO_LSB +: 3];
      next_irq_req = dat_i[IRQ_REQ_BIT];
    end
    if (done && mode == MODE_ONE_SHOT) begin
      next_irq_req = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl    <= CTRL_RESET;
      prio    <= PRIO_RESET;
      irq_req <= 1'b0;
    end else if (ce_i) begin
      ctrl    <= next_ctrl;
      prio    <= next_prio;
      irq_req <= next_irq_req;
    end
  end

  // ***********************************************************
  // result registers and channel enables
  // ***********************************************************
  for (genvar i = 0; i < 8; i++) begin : g_chan
    logic [7:0] next_result;
    always_comb begin
      next_result = result[i];
      if (done && ch == 3'(i)) begin
        next_result = final_code;
      end
    end
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        result[i] <= RESULT_RESET;
      end else if (ce_i) begin
        result[i] <= next_result;
      end
    end
    // only selected channel leaves port use
    assign analog_in_en_o[i] = (ch == 3'(i)) &&
                               (mode == MODE_ONE_SHOT || mode == MODE_REPEAT);
  end

  // ***********************************************************
  // bus slave
  // ***********************************************************
  always_comb begin
    next_ack = cyc_i & stb_i & ~ack_o;
    next_dat = 32'h0000_0000;
    if (rd) begin
      if (index == CTRL_INDEX) begin
        next_dat[7:0] = ctrl;
      end else if (index == IRQ_INDEX) begin
        next_dat[IRQ_REQ_BIT]     = irq_req;
        next_dat[PRIO_LSB +: 3]   = prio;
      end else if (index >= RESULT_BASE_INDEX &&
                   index <= RESULT_LAST_INDEX && !index[0]) begin
        next_dat[7:0] = result[index[3:1]];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  // ladder threshold is driven from code
  assign dac_code_o = sar;
  assign ch_sel_o   = ch;
  assign busy_o     = (state == CONV);
  assign irq_o      = irq_req;

  // ***********************************************************
  // assertions
  // ***********************************************************
  sequence s_finish;
    ce_i && done;
  endsequence

  property p_clear_at_start;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && trigger |=> sar == SAR_CLEAR && busy_o;
  endproperty
  a_clear_at_start: assert property (p_clear_at_start)
    else $error("code not cleared at start");

  property p_no_spurious_start;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && state == IDLE && !trigger |=> state == IDLE;
  endproperty
  a_no_spurious_start: assert property (p_no_spurious_start)
    else $error("conversion began without trigger");

  property p_ext_needs_start;
    @(posedge clk_i) disable iff (rst_i)
      ce_i && ext_sel && !start |-> !trigger;
  endproperty
  a_ext_needs_start: assert property (p_ext_needs_start)
    else $error("edge accepted with start flag low");

  property p_length;
    @(posedge clk_i) disable iff (rst_i)
      s_finish |-> tick && tick_cnt == CONV_TICKS - 6'h01;
  endproperty
  a_length: assert property (p_length)
    else $error("conversion not 57 ticks");

  property p_store;
    @(posedge clk_i) disable iff (rst_i)
      s_finish |=> result[$past(ch)] == $past(final_code);
  endproperty
  a_store: assert property (p_store)
    else $error("result not stored");

  property p_oneshot_irq;
    @(posedge clk_i) disable iff (rst_i)
      s_finish ##0 (mode == MODE_ONE_SHOT && !trigger)
      |=> irq_req && !busy_o;
  endproperty
  a_oneshot_irq: assert property (p_oneshot_irq)
    else $error("one-shot completion without request");

  property p_sw_clear_start;
    @(posedge clk_i) disable iff (rst_i)
      s_finish ##0 (mode == MODE_ONE_SHOT && !ext_sel && !wr_ctrl)
      |=> !start;
  endproperty
  a_sw_clear_start: assert property (p_sw_clear_start)
    else $error("start flag not cleared");

  property p_repeat;
    @(posedge clk_i) disable iff (rst_i)
      s_finish ##0 (mode == MODE_REPEAT && !wr_ctrl && !wr_irq &&
                    !trigger)
      |=> busy_o && tick_cnt == 6'h00 && start && irq_req == $past(irq_req);
  endproperty
  a_repeat: assert property (p_repeat)
    else $error("repeat mode did not restart");

  property p_divider;
    @(posedge clk_i) disable iff (rst_i)
      tick |-> div == (ctrl[FREQ_BIT] ? DIV_FAST_LAST : DIV_SLOW_LAST);
  endproperty
  a_divider: assert property (p_divider)
    else $error("conversion tick at wrong divide");

endmodule : sar_adc_sequencer

`default_nettype wire

// ### hdl/sar_adc_seq_pkg.sv
package sar_adc_seq_pkg;

  // ***********************************************************
  // bus decode
  // ***********************************************************
  localparam int          ADR_WIDTH         = 10;
  localparam int          INDEX_WIDTH       = 8;
  localparam logic [7:0]  CTRL_INDEX        = 8'h1E;
  localparam logic [7:0]  IRQ_INDEX         = 8'h70;
  localparam logic [7:0]  RESULT_BASE_INDEX = 8'h20;
  localparam logic [7:0]  RESULT_LAST_INDEX = 8'h2E;

  // ***********************************************************
  // control register fields
  // ***********************************************************
  localparam int          CH_LSB            = 0;
  localparam int          MODE_LSB          = 3;
  localparam int          TRIG_SEL_BIT      = 5;
  localparam int          START_BIT         = 6;
  localparam int          FREQ_BIT          = 7;
  localparam logic [7:0]  CTRL_RESET        = 8'h00;

  // ***********************************************************
  // interrupt control register fields
  // ***********************************************************
  localparam int          PRIO_LSB          = 0;
  localparam int          IRQ_REQ_BIT       = 3;
  localparam logic [2:0]  PRIO_RESET        = 3'h0;
  localparam logic [7:0]  RESULT_RESET      = 8'h00;

  // ***********************************************************
  // conversion modes
  // ***********************************************************
  localparam logic [1:0]  MODE_ONE_SHOT     = 2'h0;
  localparam logic [1:0]  MODE_REPEAT       = 2'h1;

  // ***********************************************************
  // timing: divider in input clocks, conversion in conversion clock ticks
  // ***********************************************************
  localparam logic [2:0]  DIV_SLOW_LAST     = 3'h7;
  localparam logic [2:0]  DIV_FAST_LAST     = 3'h3;
  localparam logic [5:0]  CONV_TICKS        = 6'h39;
  localparam logic [2:0]  BIT_TICKS         = 3'h7;
  localparam logic [7:0]  SAR_CLEAR         = 8'h00;

endpackage : sar_adc_seq_pkg

// ### dv/analog_front_model.sv
`timescale 1ns/1ps
`default_nettype none

// ***********************************************************
// comparator and reference ladder
// ***********************************************************
module analog_front_model (
  input  wire logic [7:0]      dac_code_i,
  input  wire logic [2:0]      ch_sel_i,
  input  wire logic [7:0][7:0] level_i,
  output logic                 comp_o
);
  logic [8:0] thr2;

  assign thr2 = (dac_code_i == 8'h00) ? 9'h000 : {dac_code_i, 1'b0} - 9'h001;
  assign comp_o = thr2 < {level_i[ch_sel_i], 1'b0};
endmodule : analog_front_model

`default_nettype wire

// ### dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
  import sar_adc_seq_pkg::*;
  logic            clk_i, rst_i, cyc, stb, we, irq_ack, trig_n, comp, ce;
  logic            ack, busy, irq;
  logic [9:0]      adr;
  logic [3:0]      sel;
  logic [31:0]     dat_w, dat_r;
  logic [7:0]      dac, en, rd;
  logic [2:0]      chs;
  logic [7:0][7:0] level;
  int              errors, num_checks, n, d;

  sar_adc_sequencer u_sar_adc_sequencer (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .comp_i(comp),
    .ext_conv_trigger_n_i(trig_n), .irq_ack_i(irq_ack), .dac_code_o(dac),
    .ch_sel_o(chs), .analog_in_en_o(en), .busy_o(busy), .irq_o(irq));
  analog_front_model u_analog_front_model (.dac_code_i(dac), .ch_sel_i(chs),
    .level_i(level), .comp_o(comp));

  // ***********************************************************
  // helpers
  // ***********************************************************
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic check(input logic [31:0] got, exp, input string msg);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic bus(input logic w, input logic [7:0] idx, wd);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat_w <= {24'h000000, wd};
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    check(ack, 1'b1, "no ack");
    rd = dat_r[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : bus

  task automatic wait_busy(input logic lvl, input int lim);
    n = 0;
    while (busy !== lvl && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check(busy, lvl, "busy wait");
  endtask : wait_busy

  task automatic pulse_trig();
    trig_n <= 1'b0;
    repeat (3) @(posedge clk_i);
    trig_n <= 1'b1;
    @(posedge clk_i);
  endtask : pulse_trig

  function automatic logic [7:0] ctrl(input logic [2:0] ch,
    input logic [1:0] md, input logic tr, st, fs);
    return {fs, st, tr, md, ch};
  endfunction : ctrl

  task automatic one_shot(input logic [2:0] ch, input logic fs);
    d = fs ? 4 : 8;
    bus(1'b1, CTRL_INDEX, ctrl(ch, MODE_ONE_SHOT, 1'b0, 1'b0, fs));
    check(chs, ch, "channel");
    check(en, 8'h01 << ch, "enable");
    bus(1'b1, CTRL_INDEX, ctrl(ch, MODE_ONE_SHOT, 1'b0, 1'b1, fs));
    wait_busy(1'b1, 10);
    wait_busy(1'b0, 600);
    check(n >= 56 * d - 4 && n <= 58 * d + 4, 1'b1, "time");
    @(posedge clk_i);
    check(irq, 1'b1, "irq");
    bus(1'b0, RESULT_BASE_INDEX + {ch, 1'b0}, 8'h00);
    check(rd, level[ch], "result");
    bus(1'b0, CTRL_INDEX, 8'h00);
    check(rd[START_BIT], 1'b0, "start");
    irq_ack <= 1'b1;
    @(posedge clk_i);
    irq_ack <= 1'b0;
    repeat (2) @(posedge clk_i);
    check(irq, 1'b0, "irq ack");
  endtask : one_shot

  // ***********************************************************
  // tests
  // ***********************************************************
  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    stop_test();
  end

  initial begin
    {cyc, stb, we, irq_ack, adr, sel, dat_w} = '0;
    sel = 4'hF;
    trig_n = 1'b1;
    ce = 1'b1;
    errors = 0;
    num_checks = 0;
    n = $urandom(68427);
    foreach (level[i]) level[i] = 8'($urandom_range(255, 0));
    level[0] = 8'h00;
    level[7] = 8'hFF;
    rst_i = 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check({en, irq, busy, dac}, {8'h01, 2'b00, 8'h00}, "reset");
    bus(1'b0, CTRL_INDEX, 8'h00);
    check(rd, CTRL_RESET, "ctrl reset");
    bus(1'b1, 8'h00, 8'hFF);
    bus(1'b0, 8'h00, 8'h00);
    check(rd, 8'h00, "unmapped");
    $display("reset test done");
    for (int c = 0; c < 8; c++) one_shot(3'(c), c[0]);
    bus(1'b1, IRQ_INDEX, 8'h0D);
    check(irq, 1'b1, "sw set");
    bus(1'b0, IRQ_INDEX, 8'h00);
    check(rd[3:0], 4'hD, "irq reg");
    bus(1'b1, IRQ_INDEX, 8'h00);
    check(irq, 1'b0, "sw clear");
    $display("one-shot test done");
    for (int m = 2; m < 4; m++) begin
      bus(1'b1, CTRL_INDEX, ctrl(3'h1, 2'(m), 1'b0, 1'b1, 1'b0));
      repeat (20) @(posedge clk_i);
      check(busy, 1'b0, "sweep idle");
    end
    bus(1'b1, CTRL_INDEX, ctrl(3'h3, MODE_ONE_SHOT, 1'b1, 1'b0, 1'b0));
    pulse_trig();
    repeat (20) @(posedge clk_i);
    check(busy, 1'b0, "edge no flag");
    bus(1'b1, CTRL_INDEX, ctrl(3'h3, MODE_ONE_SHOT, 1'b1, 1'b1, 1'b0));
    repeat (20) @(posedge clk_i);
    check(busy, 1'b0, "no edge");
    pulse_trig();
    wait_busy(1'b1, 10);
    repeat (200) @(posedge clk_i);
    level[3] <= 8'($urandom_range(255, 0));
    pulse_trig();
    wait_busy(1'b0, 600);
    check(n >= 56 * 8 - 12, 1'b1, "retrigger");
    @(posedge clk_i);
    check(irq, 1'b1, "ext irq");
    bus(1'b0, RESULT_BASE_INDEX + 8'h06, 8'h00);
    check(rd, level[3], "ext result");
    bus(1'b0, CTRL_INDEX, 8'h00);
    check(rd[START_BIT], 1'b1, "flag kept");
    bus(1'b1, IRQ_INDEX, 8'h00);
    $display("external test done");
    for (int t = 0; t < 2; t++) begin
      bus(1'b1, CTRL_INDEX, ctrl(3'h5, MODE_REPEAT, t[0], 1'b0, 1'b1));
      bus(1'b1, CTRL_INDEX, ctrl(3'h5, MODE_REPEAT, t[0], 1'b1, 1'b1));
      if (t == 1) pulse_trig();
      for (int r = 0; r < 2; r++) begin
        level[5] <= 8'($urandom_range(255, 0));
        repeat (2 * 57 * 4 + 40) @(posedge clk_i);
        ce <= 1'b0;
        @(posedge clk_i);
        d = dac;
        repeat (20) @(posedge clk_i);
        check(dac, d, "freeze");
        ce <= 1'b1;
        @(posedge clk_i);
        bus(1'b0, RESULT_BASE_INDEX + 8'h0A, 8'h00);
        check(rd, level[5], "repeat result");
        check({busy, irq}, 2'b10, "repeat run");
        bus(1'b0, CTRL_INDEX, 8'h00);
        check(rd[START_BIT], 1'b1, "repeat flag");
      end
      bus(1'b1, CTRL_INDEX, 8'h00);
      wait_busy(1'b0, 10);
    end
    $display("repeat test done");
    stop_test();
  end
endmodule : tb

`default_nettype wire
